//--- src/qsd_defs.vh
// Constants for the quad serial-to-parallel driver core.
// Assumes inclusion by bare name from the design files under src/.
`ifndef QSD_DEFS_VH
`define QSD_DEFS_VH

// Geometry
`define QSD_LANES        4
`define QSD_STAGES       32
`define QSD_CHANNELS     128
`define QSD_FIFO_WIDTH   32
`define QSD_FIFO_DEPTH   16

// Register byte offsets
`define QSD_REG_CTRL     12'h000
`define QSD_REG_STATUS   12'h004
`define QSD_REG_LATCH0   12'h010
`define QSD_REG_LATCH1   12'h014
`define QSD_REG_LATCH2   12'h018
`define QSD_REG_LATCH3   12'h01c
`define QSD_REG_FIFO     12'h020

// Control fields
`define QSD_CTRL_SW_LOAD 0
`define QSD_CTRL_REVERSE 1
`define QSD_CTRL_RESET   32'h0000_0000

// Status fields
`define QSD_ST_DIR       0
`define QSD_ST_OE        1
`define QSD_ST_FLO_N     2
`define QSD_ST_FHI_N     3
`define QSD_ST_CLR       4
`define QSD_ST_EMPTY     5
`define QSD_ST_FULL      6
`define QSD_ST_LVL_LSB   8

// Bus responses
`define QSD_RESP_OKAY    2'b00
`define QSD_RESP_SLVERR  2'b10

`endif

//--- src/qsd_fifo.v
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module qsd_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             rst_i,
  // Fill side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // Drain side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o,
  // Fill level
  output wire [AW:0]      level_o
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  // Honest flags from the count
  assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign out_data_o  = mem_q[rd_q];
  assign level_o     = cnt_q;
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Storage array
  always @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // Pointers and count
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- src/qsd_core.v
// Quad serial-to-parallel driver core with AXI4-Lite register access.
// Assumes all pin inputs are asynchronous to ref_clk_i and change slower
// than half the clock rate; pin edges are seen after two-flop syncing.
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "qsd_defs.vh"
module qsd_core (
  // Clock and reset
  input  wire         ref_clk_i,
  input  wire         rst_i,
  // Control pins
  input  wire         shift_clk_i,
  input  wire         direction_i,
  input  wire         latch_load_strobe_i,
  input  wire         clear_pin_i,
  input  wire         output_enable_i,
  input  wire         force_all_low_n_i,
  input  wire         force_all_high_n_i,
  // Side A lanes 1..4 as bits 0..3
  input  wire [3:0]   side_a_lane_i,
  output reg  [3:0]   side_a_lane_o,
  output reg  [3:0]   side_a_lane_oe_o,
  // Side B lanes 1..4 as bits 0..3
  input  wire [3:0]   side_b_lane_i,
  output reg  [3:0]   side_b_lane_o,
  output reg  [3:0]   side_b_lane_oe_o,
  // Channel outputs
  output reg  [127:0] driver_channel_outputs_o,
  output reg  [127:0] driver_channel_outputs_oe_o,
  // AXI4-Lite write address
  input  wire [11:0]  s_axi_awaddr,
  input  wire         s_axi_awvalid,
  output reg          s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]  s_axi_wdata,
  input  wire [3:0]   s_axi_wstrb,
  input  wire         s_axi_wvalid,
  output reg          s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]   s_axi_bresp,
  output reg          s_axi_bvalid,
  input  wire         s_axi_bready,
  // AXI4-Lite read address
  input  wire [11:0]  s_axi_araddr,
  input  wire         s_axi_arvalid,
  output reg          s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]  s_axi_rdata,
  output reg  [1:0]   s_axi_rresp,
  output reg          s_axi_rvalid,
  input  wire         s_axi_rready
);
  integer i;
  integer s;

  // Pin synchronisers: stage one feeds only stage two
  reg [14:0] sync1_q;
  reg [14:0] sync2_q;
  reg        sclk_prev_q;
  reg        le_prev_q;
  wire [14:0] pins;
  assign pins = {side_b_lane_i, side_a_lane_i, force_all_high_n_i, force_all_low_n_i,
                 output_enable_i, clear_pin_i, latch_load_strobe_i, direction_i,
                 shift_clk_i};

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_q     <= 15'h0000;
      sync2_q     <= 15'h0000;
      sclk_prev_q <= 1'b0;
      le_prev_q   <= 1'b0;
    end else begin
      sync1_q     <= pins;
      sync2_q     <= sync1_q;
      sclk_prev_q <= sync2_q[0];
      le_prev_q   <= sync2_q[2];
    end
  end

  // Synchronised pin levels
  wire       dir_s   = sync2_q[1];
  wire       clr_s   = sync2_q[3];
  wire       oe_s    = sync2_q[4];
  wire       flo_n_s = sync2_q[5];
  wire       fhi_n_s = sync2_q[6];
  wire [3:0] a_in_s  = sync2_q[10:7];
  wire [3:0] b_in_s  = sync2_q[14:11];
  wire       sclk_rise = sync2_q[0] & ~sclk_prev_q;
  wire       le_rise   = sync2_q[2] & ~le_prev_q;

  // Software control register
  reg [31:0] ctrl_q;
  wire       sw_load = ctrl_q[`QSD_CTRL_SW_LOAD];
  wire       reverse = ctrl_q[`QSD_CTRL_REVERSE];

  // Held write word, pushed once both halves of a write are in
  reg  [31:0] w_data_q;

  // FIFO between the bus and the shift registers
  wire        fifo_in_valid;
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire        fifo_out_ready;
  wire [31:0] fifo_out_data;
  wire [4:0]  fifo_level;

  qsd_fifo #(
    .WIDTH (`QSD_FIFO_WIDTH),
    .DEPTH (`QSD_FIFO_DEPTH),
    .AW    (4)
  ) u_fifo (
    .clk_i       (ref_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (w_data_q),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data),
    .level_o     (fifo_level)
  );

  // Drain stalls unless software loading is on and no pin shift is due
  assign fifo_out_ready = sw_load & ~sclk_rise;

  // Four shift registers, one word each
  reg [31:0] sr_q [0:3];
  reg [1:0]  load_idx_q;

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (i = 0; i < `QSD_LANES; i = i + 1) begin
        sr_q[i] <= 32'h0000_0000;
      end
      load_idx_q <= 2'h0;
    end else if (sclk_rise) begin
      for (i = 0; i < `QSD_LANES; i = i + 1) begin
        if (clr_s) begin
          sr_q[i] <= 32'h0000_0000;
        end else if (dir_s) begin
          sr_q[i] <= {sr_q[i][30:0], a_in_s[i]};
        end else begin
          sr_q[i] <= {b_in_s[i], sr_q[i][31:1]};
        end
      end
    end else if (fifo_out_valid & fifo_out_ready) begin
      // Software load fills registers in turn
      sr_q[load_idx_q] <= fifo_out_data;
      load_idx_q       <= load_idx_q + 2'h1;
    end
  end

  // Lane direction and serial outputs
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      side_a_lane_o    <= 4'h0;
      side_a_lane_oe_o <= 4'h0;
      side_b_lane_o    <= 4'h0;
      side_b_lane_oe_o <= 4'h0;
    end else begin
      for (i = 0; i < `QSD_LANES; i = i + 1) begin
        side_b_lane_o[i] <= sr_q[i][31];
        side_a_lane_o[i] <= sr_q[i][0];
      end
      side_b_lane_oe_o <= {4{dir_s}};
      side_a_lane_oe_o <= {4{~dir_s}};
    end
  end

  // Stage-to-channel mapping, straight or fully reversed cascade
  reg [127:0] mapped;
  always @* begin
    mapped = 128'h0;
    for (i = 0; i < `QSD_LANES; i = i + 1) begin
      for (s = 0; s < `QSD_STAGES; s = s + 1) begin
        if (reverse) begin
          mapped[i*32+s] = sr_q[3-i][31-s];
        end else begin
          mapped[i*32+s] = sr_q[i][s];
        end
      end
    end
  end

  // Latch, loaded only on strobe edges; relies on strobe low while shifting
  reg [127:0] latch_q;
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      latch_q <= 128'h0;
    end else if (le_rise) begin
      if (clr_s) begin
        latch_q <= 128'h0;
      end else begin
        latch_q <= mapped;
      end
    end
  end

  // Channel drive: enable gates all, force-low beats force-high
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      driver_channel_outputs_o    <= 128'h0;
      driver_channel_outputs_oe_o <= 128'h0;
    end else begin
      driver_channel_outputs_oe_o <= {128{oe_s}};
      if (!oe_s) begin
        driver_channel_outputs_o <= 128'h0;
      end else if (!flo_n_s) begin
        driver_channel_outputs_o <= 128'h0;
      end else if (!fhi_n_s) begin
        driver_channel_outputs_o <= {128{1'b1}};
      end else begin
        driver_channel_outputs_o <= latch_q;
      end
    end
  end

  // Write channel: hold address and data until both are in
  reg        aw_have_q;
  reg        w_have_q;
  reg [11:0] aw_addr_q;
  wire       wr_go    = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire       wr_fifo  = (aw_addr_q == `QSD_REG_FIFO);
  wire       wr_stall = wr_fifo & ~fifo_in_ready;
  assign fifo_in_valid = wr_go & wr_fifo;

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `QSD_RESP_OKAY;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 12'h000;
      w_data_q      <= 32'h0000_0000;
      ctrl_q        <= `QSD_CTRL_RESET;
    end else begin
      s_axi_awready <= ~aw_have_q & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_have_q & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
      end
      if (wr_go & ~wr_stall) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `QSD_RESP_OKAY;
        if (aw_addr_q == `QSD_REG_CTRL) begin
          if (s_axi_wstrb[0]) begin
            ctrl_q[7:0] <= w_data_q[7:0];
          end
        end else if (!wr_fifo) begin
          s_axi_bresp <= `QSD_RESP_SLVERR;
        end
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read mux
  reg [31:0] rd_word;
  reg        rd_ok;
  always @* begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (s_axi_araddr)
      `QSD_REG_CTRL:   rd_word = ctrl_q;
      `QSD_REG_STATUS: begin
        rd_word[`QSD_ST_DIR]   = dir_s;
        rd_word[`QSD_ST_OE]    = oe_s;
        rd_word[`QSD_ST_FLO_N] = flo_n_s;
        rd_word[`QSD_ST_FHI_N] = fhi_n_s;
        rd_word[`QSD_ST_CLR]   = clr_s;
        rd_word[`QSD_ST_EMPTY] = ~fifo_out_valid;
        rd_word[`QSD_ST_FULL]  = ~fifo_in_ready;
        rd_word[`QSD_ST_LVL_LSB+4:`QSD_ST_LVL_LSB] = fifo_level;
      end
      `QSD_REG_LATCH0: rd_word = latch_q[31:0];
      `QSD_REG_LATCH1: rd_word = latch_q[63:32];
      `QSD_REG_LATCH2: rd_word = latch_q[95:64];
      `QSD_REG_LATCH3: rd_word = latch_q[127:96];
      `QSD_REG_FIFO:   rd_word = 32'h0000_0000;
      default:         rd_ok   = 1'b0;
    endcase
  end

  // Read channel: one address, one answer
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `QSD_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? `QSD_RESP_OKAY : `QSD_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- verification/qsd_host_model.sv
// Host controller model: shift clock, latch strobe, clear and lane data.
// Assumes the bench resolves the two-way lanes from both sides' enables.
`timescale 1ns/100ps
`default_nettype none
module qsd_host_model (
  // Clock
  input  wire logic       clk_i,
  // Pins towards the core
  output var  logic       shift_clk_o,
  output var  logic       direction_o,
  output var  logic       strobe_o,
  output var  logic       clear_o,
  output var  logic [3:0] lane_a_o,
  output var  logic [3:0] lane_b_o
);
  // Idle levels at time zero
  initial begin
    {shift_clk_o, direction_o, strobe_o, clear_o} = 4'h4;
    {lane_a_o, lane_b_o} = 8'h0;
  end
  // Each level outlasts the core's pin synchroniser
  task automatic hold_lvl;
    repeat (4) @(posedge clk_i);
  endtask
  // Direction and clear levels
  task automatic set_ctl(input logic d, input logic c);
    begin
      direction_o <= d;
      clear_o <= c;
      hold_lvl();
    end
  endtask
  // One bit per lane; the released side carries the inverse
  task automatic shift_bit(input logic [3:0] bits);
    begin
      lane_a_o <= direction_o ? bits : ~bits;
      lane_b_o <= direction_o ? ~bits : bits;
      hold_lvl();
      shift_clk_o <= 1'b1;
      hold_lvl();
      shift_clk_o <= 1'b0;
    end
  endtask
  // Strobe pulse, only between shift bursts
  task automatic pulse_strobe;
    begin
      strobe_o <= 1'b1;
      hold_lvl();
      strobe_o <= 1'b0;
      hold_lvl();
    end
  endtask
endmodule
`default_nettype wire

//--- verification/qsd_core_props.sv
// Checker for the driver core: channel priorities, lane roles, bus timing.
// Assumes pins hold each level for several clocks; bound into qsd_core.
`timescale 1ns/100ps
`default_nettype none
`include "qsd_defs.vh"
module qsd_core_props (
  // Clock and reset
  input wire logic         ref_clk_i,
  input wire logic         rst_i,
  // Pins
  input wire logic         direction_i,
  input wire logic         latch_load_strobe_i,
  input wire logic         output_enable_i,
  input wire logic         force_all_low_n_i,
  input wire logic         force_all_high_n_i,
  input wire logic [3:0]   side_a_lane_oe_o,
  input wire logic [3:0]   side_b_lane_oe_o,
  input wire logic [127:0] driver_channel_outputs_o,
  input wire logic [127:0] driver_channel_outputs_oe_o,
  // Bus
  input wire logic [11:0]  s_axi_awaddr,
  input wire logic         s_axi_awvalid,
  input wire logic         s_axi_awready,
  input wire logic [1:0]   s_axi_bresp,
  input wire logic         s_axi_bvalid,
  input wire logic         s_axi_bready,
  input wire logic         s_axi_arvalid,
  input wire logic         s_axi_arready,
  input wire logic         s_axi_rvalid
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Enabled, no force, no strobe
  sequence quiet_run;
    output_enable_i && force_all_low_n_i && force_all_high_n_i && !latch_load_strobe_i;
  endsequence
  // Write address taken for the read-only status word
  sequence st_wr;
    s_axi_awvalid && s_axi_awready && s_axi_awaddr == `QSD_REG_STATUS;
  endsequence
  // Read address taken
  sequence rd_go;
    s_axi_arvalid && s_axi_arready;
  endsequence
  hiz_off_a: assert property (!output_enable_i [*6] |-> driver_channel_outputs_oe_o == 128'h0)
    else $error("channels driven while disabled");
  drive_on_a: assert property (output_enable_i [*6] |-> &driver_channel_outputs_oe_o)
    else $error("channels not driven while enabled");
  force_low_a: assert property ((output_enable_i && !force_all_low_n_i) [*6]
    |-> driver_channel_outputs_o == 128'h0) else $error("force low not obeyed");
  force_high_a: assert property ((output_enable_i && force_all_low_n_i && !force_all_high_n_i) [*6]
    |-> &driver_channel_outputs_o) else $error("force high not obeyed");
  latch_hold_a: assert property (quiet_run [*6] |-> $stable(driver_channel_outputs_o))
    else $error("channels changed without strobe");
  dir_high_a: assert property (direction_i [*6]
    |-> side_b_lane_oe_o == 4'hf && side_a_lane_oe_o == 4'h0) else $error("lane roles wrong, high");
  dir_low_a: assert property (!direction_i [*6]
    |-> side_a_lane_oe_o == 4'hf && side_b_lane_oe_o == 4'h0) else $error("lane roles wrong, low");
  ro_write_a: assert property (st_wr |-> ##[1:8] (s_axi_bvalid && s_axi_bresp == `QSD_RESP_SLVERR))
    else $error("status write not refused");
  read_lat_a: assert property (rd_go |=> s_axi_rvalid)
    else $error("read data late");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
endmodule
bind qsd_core qsd_core_props qsd_core_props_inst (
  .ref_clk_i, .rst_i, .direction_i, .latch_load_strobe_i, .output_enable_i,
  .force_all_low_n_i, .force_all_high_n_i, .side_a_lane_oe_o, .side_b_lane_oe_o,
  .driver_channel_outputs_o, .driver_channel_outputs_oe_o, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid
);
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the driver core: shifting, latch, forces, bus.
// Assumes the host model drives the serial pins; the bench is bus master.
`timescale 1ns/100ps
`default_nettype none
`include "qsd_defs.vh"
module testbench;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, oe = 1'b1, fl_n = 1'b1, fh_n = 1'b1;
  logic sclk, dir, le, clr;
  logic [3:0] ha, hb, a_o, a_oe, b_o, b_oe;
  logic [127:0] ch, ch_oe, pat, e;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  integer error_cnt = 0, checks = 0, i;
  // Lane wires resolved from both drivers
  wire [3:0] a_w = (a_oe & a_o) | (~a_oe & ha);
  wire [3:0] b_w = (b_oe & b_o) | (~b_oe & hb);
  always #25 ref_clk_i = ~ref_clk_i;
  qsd_host_model qsd_host_model_inst (.clk_i(ref_clk_i), .shift_clk_o(sclk),
    .direction_o(dir), .strobe_o(le), .clear_o(clr), .lane_a_o(ha), .lane_b_o(hb));
  qsd_core qsd_core_inst (.ref_clk_i, .rst_i, .shift_clk_i(sclk), .direction_i(dir),
    .latch_load_strobe_i(le), .clear_pin_i(clr), .output_enable_i(oe),
    .force_all_low_n_i(fl_n), .force_all_high_n_i(fh_n), .side_a_lane_i(a_w),
    .side_a_lane_o(a_o), .side_a_lane_oe_o(a_oe), .side_b_lane_i(b_w),
    .side_b_lane_o(b_o), .side_b_lane_oe_o(b_oe), .driver_channel_outputs_o(ch),
    .driver_channel_outputs_oe_o(ch_oe), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // Verdict and end of run
  task automatic summarize;
    begin
      $display("checks=%0d error_cnt=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // Compare one value
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // Bus write, address and data offered together
  task automatic axw(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rsp);
    integer n;
    begin
      @(posedge ref_clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      for (n = 0; n < 200; n = n + 1) begin
        @(posedge ref_clk_i);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid) begin
          rsp = s_axi_bresp;
          s_axi_bready <= 1'b0;
          n = 300;
        end
      end
      if (n == 200) begin
        error_cnt = error_cnt + 1;
        summarize();
      end
    end
  endtask
  // Bus read
  task automatic axr(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rsp);
    integer n;
    begin
      @(posedge ref_clk_i);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      for (n = 0; n < 200; n = n + 1) begin
        @(posedge ref_clk_i);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) begin
          {v, rsp} = {s_axi_rdata, s_axi_rresp};
          s_axi_rready <= 1'b0;
          n = 300;
        end
      end
      if (n == 200) begin
        error_cnt = error_cnt + 1;
        summarize();
      end
    end
  endtask
  // Shift pat into the four registers in the given direction
  task automatic load_pat(input logic hi);
    integer j, k;
    begin
      qsd_host_model_inst.set_ctl(hi, 1'b0);
      for (j = 0; j < 32; j = j + 1) begin
        k = hi ? 31 - j : j;
        qsd_host_model_inst.shift_bit({pat[96+k], pat[64+k], pat[32+k], pat[k]});
      end
      @(negedge ref_clk_i);
    end
  endtask
  // Strobe and settle
  task automatic strobe;
    begin
      qsd_host_model_inst.pulse_strobe();
      @(negedge ref_clk_i);
    end
  endtask
  // A toward B, latch, read back
  task automatic t_shift_high;
    begin
      pat = 128'h8000_0001_c3a5_5a3c_0f0f_f0f0_1234_5678;
      load_pat(1'b1);
      chk(b_o, {pat[127], pat[95], pat[63], pat[31]});
      strobe();
      chk(ch, pat);
      chk(ch_oe, {128{1'b1}});
      for (i = 0; i < 4; i = i + 1) begin
        axr(`QSD_REG_LATCH0 + 12'(4 * i), d, r);
        chk(d, pat[32*i+:32]);
      end
      $display("test shift_high done");
    end
  endtask
  // B toward A, then reversed mapping
  task automatic t_shift_low;
    integer j;
    begin
      pat = ~pat;
      load_pat(1'b0);
      chk(a_o, {pat[96], pat[64], pat[32], pat[0]});
      strobe();
      chk(ch, pat);
      axw(`QSD_REG_CTRL, 32'h2, r);
      strobe();
      for (j = 0; j < 128; j = j + 1) e[j] = pat[127-j];
      chk(ch, e);
      axw(`QSD_REG_CTRL, 32'h0, r);
      strobe();
      $display("test shift_low done");
    end
  endtask
  // Every enable and force combination
  task automatic t_force;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        @(posedge ref_clk_i);
        {oe, fl_n, fh_n} <= 3'(i);
        repeat (6) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        e = !oe ? 128'h0 : !fl_n ? 128'h0 : !fh_n ? {128{1'b1}} : pat;
        chk(ch, e);
        chk(ch_oe, {128{oe}});
      end
      $display("test force done");
    end
  endtask
  // Clear pin at strobe and at shift edges
  task automatic t_clear;
    begin
      qsd_host_model_inst.set_ctl(1'b1, 1'b1);
      strobe();
      chk(ch, 128'h0);
      qsd_host_model_inst.set_ctl(1'b1, 1'b0);
      strobe();
      chk(ch, pat);
      qsd_host_model_inst.set_ctl(1'b1, 1'b1);
      qsd_host_model_inst.shift_bit(4'hf);
      qsd_host_model_inst.set_ctl(1'b1, 1'b0);
      strobe();
      chk(ch, 128'h0);
      $display("test clear done");
    end
  endtask
  // Status, refusals, FIFO fill and drain into the registers
  task automatic t_bus;
    begin
      axr(`QSD_REG_STATUS, d, r);
      chk(d, 32'h2f);
      axr(12'h100, d, r);
      chk({r, d}, {`QSD_RESP_SLVERR, 32'h0});
      axw(`QSD_REG_STATUS, 32'h1, r);
      chk(r, `QSD_RESP_SLVERR);
      for (i = 0; i < 16; i = i + 1) axw(`QSD_REG_FIFO, 32'h1000_0000 + i, r);
      axr(`QSD_REG_STATUS, d, r);
      chk(d, 32'h104f);
      axw(`QSD_REG_CTRL, 32'h1, r);
      d = 32'h0;
      for (i = 0; i < 10 && !d[5]; i = i + 1) axr(`QSD_REG_STATUS, d, r);
      chk(d[6:5], 2'h1);
      axw(`QSD_REG_CTRL, 32'h0, r);
      strobe();
      chk(ch, {32'h1000_000f, 32'h1000_000e, 32'h1000_000d, 32'h1000_000c});
      $display("test bus done");
    end
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_shift_high();
    t_shift_low();
    t_force();
    t_clear();
    t_bus();
    summarize();
  end
endmodule
`default_nettype wire
